// >>> aer_correctable_error_regs_bench.sv
`timescale 1ns/1ps
`include "aercr_regs.vh"
// ==========================================
// Bench
module aer_correctable_error_regs_bench;
  logic clk = 0, sys_rst = 1, sticky_rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, first = 0, lock = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, seed = 32'h2bcf_d68b;
  logic [5:0] evt = 0;
  logic [4:0] idx = 0;
  logic [127:0] hdr = 0;
  wire awready, wready, bvalid, arready, rvalid, rep, gen, chkon, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int fail_count = 0, total_checks = 0, cyc = 0, rep_cnt, k;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  aercr_regs dut (.clk(clk), .sys_rst(sys_rst), .sticky_rst(sticky_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .receiver_error(evt[0]),
    .bad_packet(evt[1]), .bad_link_packet(evt[2]), .replay_rollover(evt[3]), .replay_timeout(evt[4]),
    .advisory_nonfatal(evt[5]), .uncorr_first(first), .uncorr_index(idx), .uncorr_header(hdr),
    .reg_lock(lock), .corr_report(rep), .crc_gen_enable(gen), .crc_check_enable(chkon), .irq(irq));
  aercr_root root (.clk(clk), .corr_report(rep), .rep_cnt(rep_cnt));
  initial forever #4 clk = ~clk;
  task summarize;
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic [31:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    rnd = seed;
  endfunction
  // A hang ends the run through the same closing report.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      summarize();
    end
  end
  always @(posedge clk) begin
    if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready) chk("read word", {rresp, rdata}, rq.pop_front());
  end
  task wr(input [11:0] a, input [31:0] d, input [1:0] r);
    @(posedge clk);
    bq.push_back(r);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awv <= 0;
      if (wready) wv <= 0;
    end while (!(bvalid && bready));
    bready <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e, input [1:0] r);
    @(posedge clk);
    rq.push_back({r, e});
    araddr <= a; arv <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arv <= 0;
    end while (!(rvalid && rready));
    rready <= 0;
  endtask
  task ev(input int i, input int e);
    int n;
    n = rep_cnt;
    @(posedge clk) evt <= 6'(1 << i);
    @(posedge clk) evt <= 0;
    repeat (3) @(posedge clk);
    chk("reports", 34'(rep_cnt - n), 34'(e));
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0; sticky_rst <= 0;
    rd(`AERCR_OFF_FLAGS, 0, 0);
    rd(`AERCR_OFF_MASK, `AERCR_MASK_RST, 0);
    rd(`AERCR_OFF_CTRL, `AERCR_CTRL_RST, 0);
    rd(12'h100, 0, `AERCR_RESP_SLVERR);
    wr(12'h100, rnd(), `AERCR_RESP_SLVERR);
    for (k = 0; k < 6; k++) ev(k, k != 5);
    rd(`AERCR_OFF_FLAGS, `AERCR_CORR_IMPL, 0);
    wr(`AERCR_OFF_FLAGS, 0, 0);
    rd(`AERCR_OFF_FLAGS, `AERCR_CORR_IMPL, 0);
    wr(`AERCR_OFF_FLAGS, 32'h0000_0041, 0);
    rd(`AERCR_OFF_FLAGS, 32'h0000_3180, 0);
    wr(`AERCR_OFF_MASK, 32'hffff_ffff, 0);
    rd(`AERCR_OFF_MASK, `AERCR_CORR_IMPL, 0);
    ev(0, 0);
    wr(`AERCR_OFF_MASK, 0, 0);
    ev(5, 1);
    lock <= 1;
    wr(`AERCR_OFF_CTRL, 32'hffff_ffff, 0);
    rd(`AERCR_OFF_CTRL, 32'h0000_01e0, 0);
    chk("crc enables", 34'({gen, chkon}), 34'h3);
    lock <= 0;
    wr(`AERCR_OFF_CTRL, 0, 0);
    rd(`AERCR_OFF_CTRL, 0, 0);
    chk("crc enables", 34'({gen, chkon}), 34'h0);
    @(posedge clk) idx <= 5'(rnd());
    hdr <= {rnd(), rnd(), rnd(), rnd()};
    first <= 1;
    @(posedge clk) first <= 0;
    rd(`AERCR_OFF_CTRL, {27'h0, idx}, 0);
    for (k = 0; k < 4; k++) rd(12'(`AERCR_OFF_HLOG0 + 4 * k), hdr[32 * k +: 32], 0);
    wr(`AERCR_OFF_IRQ_EN, 32'h0000_003f, 0);
    repeat (2) @(posedge clk);
    chk("irq", 34'(irq), 34'h1);
    wr(`AERCR_OFF_IRQ_CLR, 32'h0000_003f, 0);
    repeat (2) @(posedge clk);
    chk("irq", 34'(irq), 34'h0);
    ev(1, 1);
    chk("irq", 34'(irq), 34'h1);
    rd(`AERCR_OFF_IRQ_STAT, 32'h0000_0002, 0);
    wr(`AERCR_OFF_IRQ_EN, 0, 0);
    repeat (2) @(posedge clk);
    chk("irq", 34'(irq), 34'h0);
    @(posedge clk) sys_rst <= 1;
    repeat (3) @(posedge clk);
    sys_rst <= 0;
    rd(`AERCR_OFF_FLAGS, `AERCR_CORR_IMPL, 0);
    rd(`AERCR_OFF_CTRL, {27'h5, idx}, 0);
    summarize();
  end
endmodule // aer_correctable_error_regs_bench

// >>> aercr_regs.v
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "aercr_regs.vh"
// What this block does
// - Receiver error sets flag bit 0.
// - Bad packet sets flag bit 6.
// - Bad link packet sets flag bit 7.
// - Replay rollover sets flag bit 8.
// - Replay timeout sets flag bit 12.
// - Advisory non-fatal error sets flag bit 13.
// - Flags reset zero, write-one clears, sticky.
// - Masked events are not reported upstream.
// - Mask sticky RW, advisory bit resets one.
// - First error index, read-only sticky, resets zero.
// - Generation capable bit, resets one, lockable.
// - Generation enable drives ECRC generation.
// - Check capable bit, resets one, lockable.
// - Check enable drives ECRC checking.
// - Capture header of first uncorrectable error.
module aercr_regs (
  input wire clk, // 125 MHz clock
  input wire sys_rst, // synchronous reset, active high
  input wire sticky_rst, // fundamental reset, clears sticky state
  input wire [11:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [11:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire receiver_error, // pulse: receiver error seen
  input wire bad_packet, // pulse: bad transaction packet
  input wire bad_link_packet, // pulse: bad link packet
  input wire replay_rollover, // pulse: replay number rolled over
  input wire replay_timeout, // pulse: replay timer expired
  input wire advisory_nonfatal, // pulse: advisory non-fatal error
  input wire uncorr_first, // pulse: first uncorrectable error reported
  input wire [4:0] uncorr_index, // bit index of that error
  input wire [127:0] uncorr_header, // header of offending packet
  input wire reg_lock, // high locks the capable bits
  output reg corr_report, // pulse: unmasked correctable event to report
  output reg crc_gen_enable, // ECRC generation enabled
  output reg crc_check_enable, // ECRC checking enabled
  output reg irq // interrupt level
);
  // ==========================================================
  // State
  reg [31:0] flags_ff;
  reg [31:0] mask_ff;
  reg [4:0] first_error_index_ff;
  reg crc_gen_capable_ff;
  reg crc_gen_enable_ff;
  reg crc_check_capable_ff;
  reg crc_check_enable_ff;
  reg [127:0] hlog_ff;
  reg [5:0] irq_stat_ff;
  reg [5:0] irq_en_ff;
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  wire [5:0] ev;
  wire [31:0] ev_vec;
  wire [11:0] waddr;
  wire unmasked;
  reg [31:0] rd_mux;
  reg rd_hit;
  reg wr_hit;
  reg [31:0] ctrl_word;
  localparam [31:0] FLAG_IMPL = `AERCR_CORR_IMPL;
  localparam [31:0] MASK_RESET = `AERCR_MASK_RST;

  assign ev = {advisory_nonfatal, replay_timeout, replay_rollover, bad_link_packet, bad_packet, receiver_error};
  // Each event lands on its own flag position.
  assign ev_vec = ({31'h0000_0000, ev[0]} << `AERCR_BIT_RCV)
    | ({31'h0000_0000, ev[1]} << `AERCR_BIT_BADPKT)
    | ({31'h0000_0000, ev[2]} << `AERCR_BIT_BADLNK)
    | ({31'h0000_0000, ev[3]} << `AERCR_BIT_ROLL)
    | ({31'h0000_0000, ev[4]} << `AERCR_BIT_RTO)
    | ({31'h0000_0000, ev[5]} << `AERCR_BIT_ADV);
  assign unmasked = |(ev_vec & ~mask_ff & `AERCR_CORR_IMPL);

  // ==========================================================
  // AXI4-Lite write path
  // Address and data are latched independently so either may come first.
  assign waddr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;

  always @* begin
    case (waddr)
      `AERCR_OFF_FLAGS, `AERCR_OFF_MASK, `AERCR_OFF_CTRL, `AERCR_OFF_HLOG0, `AERCR_OFF_HLOG1,
      `AERCR_OFF_HLOG2, `AERCR_OFF_HLOG3, `AERCR_OFF_IRQ_STAT, `AERCR_OFF_IRQ_CLR,
      `AERCR_OFF_IRQ_EN: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AERCR_RESP_OKAY;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= `AERCR_ZERO32;
      wstrb_ff <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_hold_ff & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready <= ~w_hold_ff & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (aw_hold_ff & w_hold_ff & ~s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `AERCR_RESP_OKAY : `AERCR_RESP_SLVERR;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire commit;
  assign commit = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  wire wr_flags;
  wire wr_mask;
  wire wr_ctrl;
  wire wr_iclr;
  wire wr_ien;
  assign wr_flags = commit & (awaddr_ff == `AERCR_OFF_FLAGS);
  assign wr_mask = commit & (awaddr_ff == `AERCR_OFF_MASK);
  assign wr_ctrl = commit & (awaddr_ff == `AERCR_OFF_CTRL);
  assign wr_iclr = commit & (awaddr_ff == `AERCR_OFF_IRQ_CLR);
  assign wr_ien = commit & (awaddr_ff == `AERCR_OFF_IRQ_EN);
  wire [31:0] cw;
  wire [31:0] cm;
  // Byte strobes widen to a bit mask so a partial write leaves the other bytes alone.
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_strb
      assign cm[8 * gb +: 8] = {8{wstrb_ff[gb]}};
      assign cw[8 * gb +: 8] = {8{wstrb_ff[gb]}} & wdata_ff[8 * gb +: 8];
    end
  endgenerate

  // ==========================================================
  // Sticky error state
  // Only the fundamental reset clears these, so a hot reset leaves logs intact.
  always @(posedge clk) begin
    if (sticky_rst) begin
      first_error_index_ff <= 5'h00;
      crc_gen_enable_ff <= 1'b0;
      crc_check_enable_ff <= 1'b0;
      hlog_ff <= {4{`AERCR_ZERO32}};
    end else begin
      if (wr_ctrl & cm[`AERCR_BIT_GEN])
        crc_gen_enable_ff <= cw[`AERCR_BIT_GEN];
      if (wr_ctrl & cm[`AERCR_BIT_CHK])
        crc_check_enable_ff <= cw[`AERCR_BIT_CHK];
      if (uncorr_first) begin
        first_error_index_ff <= uncorr_index;
        hlog_ff <= uncorr_header;
      end
    end
  end

  // ==========================================================
  // Correctable error flags and their mask, one bit per position
  // Positions that carry no event are held at zero, so reserved bits read zero.
  // A new event wins over a clear in the same cycle, so no error is ever lost.
  genvar gf;
  generate
    for (gf = 0; gf < 32; gf = gf + 1) begin : g_flag
      if (FLAG_IMPL[gf]) begin : g_live
        always @(posedge clk) begin
          if (sticky_rst) begin
            flags_ff[gf] <= 1'b0;
          end else if (ev_vec[gf]) begin
            flags_ff[gf] <= 1'b1;
          end else if (wr_flags & cw[gf]) begin
            flags_ff[gf] <= 1'b0;
          end
        end
        always @(posedge clk) begin
          if (sticky_rst) begin
            mask_ff[gf] <= MASK_RESET[gf];
          end else if (wr_mask & cm[gf]) begin
            mask_ff[gf] <= cw[gf];
          end
        end
      end else begin : g_rsvd
        always @(posedge clk) begin
          flags_ff[gf] <= 1'b0;
          mask_ff[gf] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Lockable capability bits, non-sticky
  always @(posedge clk) begin
    if (sys_rst) begin
      crc_gen_capable_ff <= `AERCR_CAP_RST;
      crc_check_capable_ff <= `AERCR_CAP_RST;
    end else if (wr_ctrl & ~reg_lock) begin
      if (cm[`AERCR_BIT_GCAP])
        crc_gen_capable_ff <= cw[`AERCR_BIT_GCAP];
      if (cm[`AERCR_BIT_CCAP])
        crc_check_capable_ff <= cw[`AERCR_BIT_CCAP];
    end
  end

  // ==========================================================
  // Interrupt status, clear and enable
  genvar gi;
  generate
    for (gi = 0; gi < `AERCR_IRQ_W; gi = gi + 1) begin : g_irq
      always @(posedge clk) begin
        if (sys_rst) begin
          irq_stat_ff[gi] <= 1'b0;
          irq_en_ff[gi] <= 1'b0;
        end else begin
          if (ev[gi])
            irq_stat_ff[gi] <= 1'b1;
          else if (wr_iclr & cw[gi])
            irq_stat_ff[gi] <= 1'b0;
          if (wr_ien & cm[gi])
            irq_en_ff[gi] <= cw[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Registered outputs
  always @(posedge clk) begin
    if (sys_rst) begin
      corr_report <= 1'b0;
      crc_gen_enable <= 1'b0;
      crc_check_enable <= 1'b0;
      irq <= 1'b0;
    end else begin
      corr_report <= unmasked;
      crc_gen_enable <= crc_gen_enable_ff;
      crc_check_enable <= crc_check_enable_ff;
      irq <= |(irq_stat_ff & irq_en_ff);
    end
  end

  // ==========================================================
  // Control word as software sees it
  // Fields are placed by name so a moved field cannot shift its neighbour.
  always @* begin
    ctrl_word = `AERCR_ZERO32;
    ctrl_word[`AERCR_PTR_HI:`AERCR_PTR_LO] = first_error_index_ff;
    ctrl_word[`AERCR_BIT_GCAP] = crc_gen_capable_ff;
    ctrl_word[`AERCR_BIT_GEN] = crc_gen_enable_ff;
    ctrl_word[`AERCR_BIT_CCAP] = crc_check_capable_ff;
    ctrl_word[`AERCR_BIT_CHK] = crc_check_enable_ff;
  end

  // ==========================================================
  // AXI4-Lite read path
  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `AERCR_OFF_FLAGS: rd_mux = flags_ff;
      `AERCR_OFF_MASK: rd_mux = mask_ff;
      `AERCR_OFF_CTRL: rd_mux = ctrl_word;
      `AERCR_OFF_HLOG0: rd_mux = hlog_ff[31:0];
      `AERCR_OFF_HLOG1: rd_mux = hlog_ff[63:32];
      `AERCR_OFF_HLOG2: rd_mux = hlog_ff[95:64];
      `AERCR_OFF_HLOG3: rd_mux = hlog_ff[127:96];
      `AERCR_OFF_IRQ_STAT: rd_mux = {26'h000_0000, irq_stat_ff};
      `AERCR_OFF_IRQ_CLR: rd_mux = `AERCR_ZERO32;
      `AERCR_OFF_IRQ_EN: rd_mux = {26'h000_0000, irq_en_ff};
      default: begin
        rd_mux = `AERCR_ZERO32;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `AERCR_ZERO32;
      s_axi_rresp <= `AERCR_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `AERCR_RESP_OKAY : `AERCR_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // aercr_regs

// >>> aercr_regs.vh
`ifndef AERCR_REGS_VH
`define AERCR_REGS_VH
// ==========================================================
// Register map
`define AERCR_ADDR_W 12
`define AERCR_OFF_FLAGS 12'h110
`define AERCR_OFF_MASK 12'h114
`define AERCR_OFF_CTRL 12'h118
`define AERCR_OFF_HLOG0 12'h11C
`define AERCR_OFF_HLOG1 12'h120
`define AERCR_OFF_HLOG2 12'h124
`define AERCR_OFF_HLOG3 12'h128
`define AERCR_OFF_IRQ_STAT 12'h140
`define AERCR_OFF_IRQ_CLR 12'h144
`define AERCR_OFF_IRQ_EN 12'h148
// ==========================================================
// Field layout
`define AERCR_BIT_RCV 0
`define AERCR_BIT_BADPKT 6
`define AERCR_BIT_BADLNK 7
`define AERCR_BIT_ROLL 8
`define AERCR_BIT_RTO 12
`define AERCR_BIT_ADV 13
`define AERCR_CORR_IMPL 32'h0000_31C1
`define AERCR_MASK_RST 32'h0000_2000
`define AERCR_PTR_HI 4
`define AERCR_PTR_LO 0
`define AERCR_BIT_GCAP 5
`define AERCR_BIT_GEN 6
`define AERCR_BIT_CCAP 7
`define AERCR_BIT_CHK 8
`define AERCR_CTRL_RST 32'h0000_00A0
`define AERCR_CAP_RST 1'b1
`define AERCR_IRQ_W 6
`define AERCR_RESP_OKAY 2'b00
`define AERCR_RESP_SLVERR 2'b10
`define AERCR_ZERO32 32'h0000_0000
`endif

// >>> aercr_regs_sva.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module aercr_chk (
  input wire clk, // clock
  input wire sys_rst, // bus reset
  input wire sticky_rst, // sticky reset
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire [31:0] s_axi_rdata, // read data
  input wire receiver_error, // event
  input wire bad_packet, // event
  input wire bad_link_packet, // event
  input wire replay_rollover, // event
  input wire replay_timeout, // event
  input wire advisory_nonfatal, // event
  input wire corr_report, // report
  input wire crc_gen_enable, // generation on
  input wire crc_check_enable, // checking on
  input wire irq // interrupt
);
  wire ev = receiver_error | bad_packet | bad_link_packet | replay_rollover | replay_timeout | advisory_nonfatal;
  default clocking cb @(posedge clk); endclocking
  property p_rep_cause;
    disable iff (sys_rst) corr_report |-> $past(ev) || $past(ev, 2);
  endproperty
  a_rep_cause: assert property (p_rep_cause) else $error("report without event");
  property p_rep_quiet;
    disable iff (sys_rst) !ev [*3] |=> !corr_report;
  endproperty
  a_rep_quiet: assert property (p_rep_quiet) else $error("report while idle");
  property p_sticky_off;
    sticky_rst ##1 sticky_rst |=> !crc_gen_enable && !crc_check_enable;
  endproperty
  a_sticky_off: assert property (p_sticky_off) else $error("crc enable after reset");
  property p_rst_quiet;
    sys_rst ##1 sys_rst |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !corr_report;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  property p_b_hold;
    disable iff (sys_rst) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    disable iff (sys_rst) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed");
  property p_b_bound;
    disable iff (sys_rst) s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid;
  endproperty
  a_b_bound: assert property (p_b_bound) else $error("write answer late");
  property p_r_bound;
    disable iff (sys_rst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_bound: assert property (p_r_bound) else $error("read answer late");
endmodule // aercr_chk
bind aercr_regs aercr_chk u_chk (.clk(clk), .sys_rst(sys_rst), .sticky_rst(sticky_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .receiver_error(receiver_error), .bad_packet(bad_packet), .bad_link_packet(bad_link_packet),
  .replay_rollover(replay_rollover), .replay_timeout(replay_timeout), .advisory_nonfatal(advisory_nonfatal),
  .corr_report(corr_report), .crc_gen_enable(crc_gen_enable), .crc_check_enable(crc_check_enable), .irq(irq));

// >>> aercr_root.sv
`timescale 1ns/1ps
// ==========================================
// Upstream report counter
module aercr_root (
  input wire clk, // port clock
  input wire corr_report, // report pulse from the port
  output int rep_cnt = 0 // reports received so far
);
  always @(posedge clk) if (corr_report) rep_cnt <= rep_cnt + 1;
endmodule // aercr_root
